// ---- aec_core.sv ----
/*
 Auto exposure controller: statistics, filter, enforcer and register file.
 Assumes pixel, frame and coordinate inputs come from readout logic on core_clk.
*/
`timescale 1ns/1ps
module aec_core
	import aec_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic frame_start,
	input wire logic frame_end,
	input wire logic pix_valid,
	input wire logic pix_repeat,
	input wire logic [9:0] pix_data,
	input wire logic [1:0] pix_colour,
	input wire logic [11:0] pix_x,
	input wire logic [11:0] pix_y,
	input wire logic out8_mode,
	input wire logic [15:0] manual_exposure,
	input wire logic [1:0] manual_mux_gain,
	input wire logic [1:0] manual_afe_gain,
	input wire logic [11:0] manual_dig_gain,
	output logic [15:0] exposure_out,
	output logic [1:0] mux_gain_out,
	output logic [1:0] afe_gain_out,
	output logic [11:0] dig_gain_out,
	output logic pix_out_valid,
	output logic [9:0] pix_out_data
);
	logic [15:0] ctrl_reg, target_reg, wgt_reg [4], int_lo_reg, int_hi_reg, gain_lo_reg, gain_hi_reg;
	logic [15:0] win_ctrl_reg, again_ctrl_reg, win_reg [3];
	logic [1:0] sub_cnt_reg;
	logic [31:0] sum_reg, quo_reg;
	logic [23:0] cnt_reg, cnt_hold_reg;
	logic [32:0] rem_reg;
	logic [5:0] div_cnt_reg;
	logic [9:0] avg_reg;
	logic [12:0] filt_reg;
	logic [15:0] exp_reg;
	logic [1:0] mux_reg, afe_reg, mux_dly_reg, afe_dly_reg, mux_app_reg, afe_app_reg;
	logic [11:0] dig_reg, dig_dly_reg, dig_app_reg;
	logic eval_frame_reg;
	aec_state_t state_reg, state_next;
	logic loop_en, eligible, take;
	logic [19:0] wprod;
	logic [9:0] tgt_cmp, avg_cmp;
	logic signed [12:0] err, filt_next;
	logic [32:0] rem_shift;

	function automatic logic [15:0] clampv(input int v, input int lo, input int hi);
		int r;
		r = v;
		if (r > hi) r = hi;
		if (r < lo) r = lo;
		return 16'(r);
	endfunction : clampv

	// [R24] loop enable
	assign loop_en = ctrl_reg[BIT_LOOP_ENABLE];

	// Register writes
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_reg <= RST_EXPOSURE_CONTROL;
			target_reg <= RST_TARGET;
			for (int i = 0; i < 4; i++) wgt_reg[i] <= RST_WEIGHT;
			int_lo_reg <= RST_INT_LOWER;
			int_hi_reg <= RST_INT_UPPER;
			gain_lo_reg <= RST_GAIN_LOWER;
			gain_hi_reg <= RST_GAIN_UPPER;
			win_ctrl_reg <= RST_WINDOW_CONTROL;
			again_ctrl_reg <= RST_ANALOG_GAIN_CONTROL;
			for (int i = 0; i < 3; i++) win_reg[i] <= RST_WINDOW;
		end else begin
			// [R10] restart self-clears
			if (ctrl_reg[BIT_FILTER_RESTART]) ctrl_reg[BIT_FILTER_RESTART] <= 1'b0;
			if (reg_wr) begin
				case (reg_addr)
					ADDR_EXPOSURE_CONTROL: ctrl_reg <= reg_wdata;
					ADDR_TARGET_INTENSITY: target_reg <= {6'h00, reg_wdata[9:0]};
					ADDR_RED_WEIGHT: wgt_reg[0] <= {6'h00, reg_wdata[9:0]};
					ADDR_FIRST_GREEN_WEIGHT: wgt_reg[1] <= {6'h00, reg_wdata[9:0]};
					ADDR_SECOND_GREEN_WEIGHT: wgt_reg[2] <= {6'h00, reg_wdata[9:0]};
					ADDR_BLUE_WEIGHT: wgt_reg[3] <= {6'h00, reg_wdata[9:0]};
					ADDR_INTEGRATION_LOWER_BOUND: int_lo_reg <= reg_wdata;
					ADDR_GAIN_LOWER_BOUNDS: gain_lo_reg <= reg_wdata;
					ADDR_INTEGRATION_UPPER_BOUND: int_hi_reg <= reg_wdata;
					ADDR_GAIN_UPPER_BOUNDS: gain_hi_reg <= reg_wdata;
					ADDR_STATISTICS_WINDOW_CONTROL: win_ctrl_reg <= reg_wdata;
					ADDR_ANALOG_GAIN_CONTROL: again_ctrl_reg <= reg_wdata;
					ADDR_STATISTICS_WINDOW_0: win_reg[0] <= reg_wdata;
					ADDR_STATISTICS_WINDOW_1: win_reg[1] <= {4'h0, reg_wdata[11:0]};
					ADDR_STATISTICS_WINDOW_2: win_reg[2] <= {4'h0, reg_wdata[11:0]};
					default: ;
				endcase
			end
		end
	end

	// Register reads, unmapped offsets read zero
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
		end else begin
			case (reg_addr)
				ADDR_EXPOSURE_CONTROL: reg_rdata <= ctrl_reg;
				ADDR_TARGET_INTENSITY: reg_rdata <= target_reg;
				ADDR_RED_WEIGHT: reg_rdata <= wgt_reg[0];
				ADDR_FIRST_GREEN_WEIGHT: reg_rdata <= wgt_reg[1];
				ADDR_SECOND_GREEN_WEIGHT: reg_rdata <= wgt_reg[2];
				ADDR_BLUE_WEIGHT: reg_rdata <= wgt_reg[3];
				ADDR_INTEGRATION_LOWER_BOUND: reg_rdata <= int_lo_reg;
				ADDR_GAIN_LOWER_BOUNDS: reg_rdata <= gain_lo_reg;
				ADDR_INTEGRATION_UPPER_BOUND: reg_rdata <= int_hi_reg;
				ADDR_GAIN_UPPER_BOUNDS: reg_rdata <= gain_hi_reg;
				ADDR_STATISTICS_WINDOW_CONTROL: reg_rdata <= win_ctrl_reg;
				ADDR_ANALOG_GAIN_CONTROL: reg_rdata <= again_ctrl_reg;
				ADDR_STATISTICS_WINDOW_0: reg_rdata <= win_reg[0];
				ADDR_STATISTICS_WINDOW_1: reg_rdata <= win_reg[1];
				ADDR_STATISTICS_WINDOW_2: reg_rdata <= win_reg[2];
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

	// [R2] [R3] [R4] [R5] sample eligibility
	assign eligible = pix_valid && !pix_repeat && (!win_ctrl_reg[BIT_WINDOW_SELECT] ||
		(pix_x >= {4'h0, win_reg[0][7:0]} && pix_x <= {4'h0, win_reg[0][15:8]} &&
		pix_y >= win_reg[1][11:0] && pix_y <= win_reg[2][11:0]));
	// [R1] one in four
	assign take = eligible && (sub_cnt_reg == 2'h0);
	// [R8] [R9] weighted sample, 3.7 format
	assign wprod = pix_data * wgt_reg[pix_colour][9:0];

	// Statistics accumulation
	always_ff @(posedge core_clk) begin
		if (sys_rst || frame_start) begin
			sub_cnt_reg <= 2'h0;
			sum_reg <= 32'h00000000;
			cnt_reg <= 24'h000000;
		end else if (eligible) begin
			sub_cnt_reg <= sub_cnt_reg + 2'h1;
			if (take) begin
				sum_reg <= sum_reg + {19'h00000, wprod[19:7]};
				cnt_reg <= cnt_reg + 24'h000001;
			end
		end
	end

	// [R21] every second frame
	always_ff @(posedge core_clk) begin
		if (sys_rst || !loop_en) eval_frame_reg <= 1'b0;
		else if (frame_end) eval_frame_reg <= !eval_frame_reg;
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			AEC_IDLE: if (frame_end && eval_frame_reg && loop_en) state_next = AEC_DIVIDE;
			AEC_DIVIDE: if (div_cnt_reg == 6'h00) state_next = AEC_ADJUST;
			AEC_ADJUST: state_next = AEC_IDLE;
			default: state_next = AEC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) state_reg <= AEC_IDLE;
		else state_reg <= state_next;
	end

	// Average by restoring division
	assign rem_shift = {rem_reg[31:0], quo_reg[31]};
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			quo_reg <= 32'h00000000;
			rem_reg <= 33'h000000000;
			div_cnt_reg <= 6'h00;
			cnt_hold_reg <= 24'h000000;
			avg_reg <= 10'h000;
		end else if (state_reg == AEC_IDLE) begin
			quo_reg <= sum_reg;
			rem_reg <= 33'h000000000;
			div_cnt_reg <= DIV_STEPS;
			cnt_hold_reg <= cnt_reg;
		end else if (state_reg == AEC_DIVIDE) begin
			if (div_cnt_reg != 6'h00) begin
				div_cnt_reg <= div_cnt_reg - 6'h01;
				if (rem_shift >= {9'h000, cnt_hold_reg}) begin
					rem_reg <= rem_shift - {9'h000, cnt_hold_reg};
					quo_reg <= {quo_reg[30:0], 1'b1};
				end else begin
					rem_reg <= rem_shift;
					quo_reg <= {quo_reg[30:0], 1'b0};
				end
			end else if (cnt_hold_reg == 24'h000000) begin
				avg_reg <= target_reg[9:0];
			end else begin
				avg_reg <= (quo_reg > {22'h000000, PIX_MAX}) ? PIX_MAX : quo_reg[9:0];
			end
		end
	end

	// [R7] [R25] error against target
	assign tgt_cmp = out8_mode ? {target_reg[9:2], 2'b00} : target_reg[9:0];
	assign avg_cmp = out8_mode ? {avg_reg[9:2], 2'b00} : avg_reg;
	assign err = $signed({3'b000, tgt_cmp}) - $signed({3'b000, avg_cmp});
	// [R10] first-order low-pass
	assign filt_next = $signed(filt_reg) + ((err - $signed(filt_reg)) >>> 2);

	always_ff @(posedge core_clk) begin
		if (sys_rst || ctrl_reg[BIT_FILTER_RESTART]) filt_reg <= 13'h0000;
		else if (state_reg == AEC_ADJUST) filt_reg <= filt_next;
	end

	// [R11] [R12] [R13] enforcer, exposure in multiplier steps
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			exp_reg <= RST_EXPOSURE;
			mux_reg <= 2'h0;
			afe_reg <= 2'h0;
			dig_reg <= UNITY_DIG;
		end else if (state_reg == AEC_ADJUST) begin
			// [R15] [R19] second stage held at its lower bound
			afe_reg <= gain_lo_reg[POS_AFE +: 2];
			if (filt_next > LARGE_ERR) begin
				if (exp_reg < int_hi_reg)
					exp_reg <= clampv(int'(exp_reg) + int'(exp_reg >> 3) + 1, int'(int_lo_reg), int'(int_hi_reg));
				else if (mux_reg < gain_hi_reg[1:0])
					mux_reg <= mux_reg + 2'h1;
				else
					dig_reg <= 12'(clampv(int'(dig_reg) + int'(filt_next),
						int'(gain_lo_reg[15:POS_DIG]), int'(gain_hi_reg[15:POS_DIG])));
			end else if (filt_next < -LARGE_ERR) begin
				if (exp_reg > int_lo_reg)
					exp_reg <= clampv(int'(exp_reg) - int'(exp_reg >> 3) - 1, int'(int_lo_reg), int'(int_hi_reg));
				else if (mux_reg > gain_lo_reg[1:0])
					mux_reg <= mux_reg - 2'h1;
				else
					dig_reg <= 12'(clampv(int'(dig_reg) + int'(filt_next),
						int'(gain_lo_reg[15:POS_DIG]), int'(gain_hi_reg[15:POS_DIG])));
			end else if (filt_next > HYST_ERR || filt_next < -HYST_ERR) begin
				dig_reg <= 12'(clampv(int'(dig_reg) + int'(filt_next),
					int'(gain_lo_reg[15:POS_DIG]), int'(gain_hi_reg[15:POS_DIG])));
			end
		end else begin
			// [R17] [R18] [R20] bounds follow register changes
			exp_reg <= clampv(int'(exp_reg), int'(int_lo_reg), int'(int_hi_reg));
			mux_reg <= 2'(clampv(int'(mux_reg), int'(gain_lo_reg[1:0]), int'(gain_hi_reg[1:0])));
			dig_reg <= 12'(clampv(int'(dig_reg), int'(gain_lo_reg[15:POS_DIG]), int'(gain_hi_reg[15:POS_DIG])));
		end
	end

	// [R23] gain latency staging
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mux_dly_reg <= 2'h0;
			afe_dly_reg <= 2'h0;
			dig_dly_reg <= UNITY_DIG;
			mux_app_reg <= 2'h0;
			afe_app_reg <= 2'h0;
			dig_app_reg <= UNITY_DIG;
		end else if (frame_start) begin
			mux_dly_reg <= mux_reg;
			afe_dly_reg <= afe_reg;
			dig_dly_reg <= dig_reg;
			mux_app_reg <= again_ctrl_reg[BIT_GAIN_LATENCY_COMP] ? mux_dly_reg : mux_reg;
			afe_app_reg <= again_ctrl_reg[BIT_GAIN_LATENCY_COMP] ? afe_dly_reg : afe_reg;
			dig_app_reg <= again_ctrl_reg[BIT_GAIN_LATENCY_COMP] ? dig_dly_reg : dig_reg;
		end
	end

	// [R14] manual settings only while disabled
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			exposure_out <= RST_EXPOSURE;
			mux_gain_out <= 2'h0;
			afe_gain_out <= 2'h0;
			dig_gain_out <= UNITY_DIG;
		end else begin
			exposure_out <= loop_en ? exp_reg : manual_exposure;
			mux_gain_out <= loop_en ? mux_app_reg : manual_mux_gain;
			afe_gain_out <= loop_en ? afe_app_reg : manual_afe_gain;
			dig_gain_out <= loop_en ? dig_app_reg : manual_dig_gain;
		end
	end

	// [R16] [R8] digital gain on raw samples, saturating
	logic [21:0] gprod;
	assign gprod = pix_data * dig_gain_out;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pix_out_valid <= 1'b0;
			pix_out_data <= 10'h000;
		end else begin
			pix_out_valid <= pix_valid;
			pix_out_data <= (gprod[21:7] > {5'h00, PIX_MAX}) ? PIX_MAX : gprod[16:7];
		end
	end

	a_sub: assert property (@(posedge core_clk) disable iff (sys_rst) // [R1]
		take |=> !take) else $error("two samples taken back to back");
	a_dup: assert property (@(posedge core_clk) disable iff (sys_rst) // [R3]
		pix_repeat && !frame_start |=> $stable(cnt_reg)) else $error("repeat pixel counted");
	a_win: assert property (@(posedge core_clk) disable iff (sys_rst) // [R4]
		win_ctrl_reg[BIT_WINDOW_SELECT] && pix_x > {4'h0, win_reg[0][15:8]} |-> !eligible)
		else $error("pixel outside statistics window used");
	a_restart: assert property (@(posedge core_clk) disable iff (sys_rst) // [R10]
		ctrl_reg[BIT_FILTER_RESTART] |=> filt_reg == 13'h0000) else $error("filter not restarted");
	a_exp_hi: assert property (@(posedge core_clk) disable iff (sys_rst) // [R17]
		state_reg == AEC_ADJUST && int_lo_reg <= int_hi_reg |=> exp_reg <= int_hi_reg && exp_reg >= int_lo_reg)
		else $error("exposure out of bounds");
	a_afe: assert property (@(posedge core_clk) disable iff (sys_rst) // [R19]
		state_reg == AEC_ADJUST |=> afe_reg == gain_lo_reg[POS_AFE +: 2]) else $error("second stage moved");
	a_lat: assert property (@(posedge core_clk) disable iff (sys_rst) // [R23]
		frame_start && !again_ctrl_reg[BIT_GAIN_LATENCY_COMP] |=> dig_app_reg == $past(dig_reg))
		else $error("gain not applied next frame");
	a_manual: assert property (@(posedge core_clk) disable iff (sys_rst) // [R14]
		!loop_en ##1 !loop_en |-> exposure_out == $past(manual_exposure)) else $error("manual exposure not used");
	a_enable: assert property (@(posedge core_clk) disable iff (sys_rst) // [R24]
		!loop_en && state_reg == AEC_IDLE |=> state_reg == AEC_IDLE) else $error("loop ran while disabled");
	a_div: assert property (@(posedge core_clk) disable iff (sys_rst) // [R21]
		state_reg == AEC_IDLE && state_next == AEC_DIVIDE |-> ##34 state_reg == AEC_ADJUST)
		else $error("evaluation timing wrong");
	a_lat_comp: assert property (@(posedge core_clk) disable iff (sys_rst) // [R23]
		frame_start && again_ctrl_reg[BIT_GAIN_LATENCY_COMP] |=> dig_app_reg == $past(dig_dly_reg))
		else $error("gain not held one more frame");
	a_mux_bounds: assert property (@(posedge core_clk) disable iff (sys_rst) // [R18]
		state_reg == AEC_ADJUST && gain_lo_reg[1:0] <= gain_hi_reg[1:0] |=>
		mux_reg >= gain_lo_reg[1:0] && mux_reg <= gain_hi_reg[1:0])
		else $error("first stage out of bounds");
	a_dig_bounds: assert property (@(posedge core_clk) disable iff (sys_rst) // [R20]
		state_reg == AEC_ADJUST && gain_lo_reg[15:POS_DIG] <= gain_hi_reg[15:POS_DIG] |=>
		dig_reg >= gain_lo_reg[15:POS_DIG] && dig_reg <= gain_hi_reg[15:POS_DIG])
		else $error("digital gain out of bounds");
	a_small: assert property (@(posedge core_clk) disable iff (sys_rst) // [R12]
		state_reg == AEC_ADJUST && filt_next <= LARGE_ERR && filt_next >= -LARGE_ERR |=>
		$stable(exp_reg) && $stable(mux_reg)) else $error("small correction moved exposure or first stage");
	a_hyst: assert property (@(posedge core_clk) disable iff (sys_rst) // [R11]
		state_reg == AEC_ADJUST && filt_next <= HYST_ERR && filt_next >= -HYST_ERR |=> $stable(dig_reg))
		else $error("digital gain moved inside dead band");
endmodule : aec_core

// ---- aec_pkg.sv ----
/*
 Package of the auto exposure controller: register offsets, field positions,
 reset values, loop constants and the controller state type.
 Assumes registers are written over a 16-bit word port at their printed offsets.
*/
// Behaviour
// [R1] Statistics use one of every four eligible pixel samples.
// [R2] Only pixels delivered through active readout windows feed the statistics.
// [R3] Overlap repeats of a pixel are counted only once.
// [R4] Window select 0 uses all active windows; 1 uses the statistics window only.
// [R5] Statistics window pixels are its intersection with the active readout windows.
// [R6] Software keeps the statistics window overlapping an active window.
// [R7] Target is 10 bits; in 8-bit mode only bits 9:2 are compared.
// [R8] Colour weights are 3.7 factors for statistics only, never for pixels.
// [R9] Four separate 10-bit weights for red, two greens and blue.
// [R10] Gain requests are low-pass filtered; restart control clears the filter.
// [R11] Enforcer splits gain by fixed priority with digital hysteresis.
// [R12] Large corrections: exposure, then analog, then digital; small ones digital only.
// [R13] Exposure step size follows the integration time multiplier.
// [R14] Manual exposure ignored while enabled; software sets frame period setting.
// [R15] Loop adjusts only the first analog stage.
// [R16] Digital gain multiplies samples as an unsigned 5.7 factor.
// [R17] Integration time stays inside 16-bit lower and upper bounds.
// [R18] First analog stage stays inside its 2-bit bounds.
// [R19] Second analog stage stays inside its 2-bit bounds.
// [R20] Digital gain stays inside its 12-bit 5.7 bounds.
// [R21] Parameters are evaluated and updated only every second frame.
// [R22] Software sets gain latency compensation when running the loop.
// [R23] Gains apply next frame, or one frame later with compensation set.
// [R24] The loop runs only while its enable bit is set.
// [R25] Average is compared with target to form a gain change request.
package aec_pkg;
	localparam logic [7:0] ADDR_EXPOSURE_CONTROL = 8'hA0;
	localparam logic [7:0] ADDR_TARGET_INTENSITY = 8'hA1;
	localparam logic [7:0] ADDR_RED_WEIGHT = 8'hA2;
	localparam logic [7:0] ADDR_FIRST_GREEN_WEIGHT = 8'hA3;
	localparam logic [7:0] ADDR_SECOND_GREEN_WEIGHT = 8'hA4;
	localparam logic [7:0] ADDR_BLUE_WEIGHT = 8'hA5;
	localparam logic [7:0] ADDR_INTEGRATION_LOWER_BOUND = 8'hA8;
	localparam logic [7:0] ADDR_GAIN_LOWER_BOUNDS = 8'hA9;
	localparam logic [7:0] ADDR_INTEGRATION_UPPER_BOUND = 8'hAA;
	localparam logic [7:0] ADDR_GAIN_UPPER_BOUNDS = 8'hAB;
	localparam logic [7:0] ADDR_STATISTICS_WINDOW_CONTROL = 8'hC0;
	localparam logic [7:0] ADDR_ANALOG_GAIN_CONTROL = 8'hCC;
	localparam logic [7:0] ADDR_STATISTICS_WINDOW_0 = 8'hFD;
	localparam logic [7:0] ADDR_STATISTICS_WINDOW_1 = 8'hFE;
	localparam logic [7:0] ADDR_STATISTICS_WINDOW_2 = 8'hFF;
	localparam int BIT_LOOP_ENABLE = 0;
	localparam int BIT_FILTER_RESTART = 1;
	localparam int BIT_WINDOW_SELECT = 10;
	localparam int BIT_GAIN_LATENCY_COMP = 13;
	localparam int POS_AFE = 2;
	localparam int POS_DIG = 4;
	localparam logic [15:0] RST_EXPOSURE_CONTROL = 16'h0000;
	localparam logic [15:0] RST_TARGET = 16'h0200;
	localparam logic [15:0] RST_WEIGHT = 16'h0080;
	localparam logic [15:0] RST_INT_LOWER = 16'h0001;
	localparam logic [15:0] RST_INT_UPPER = 16'hFFFF;
	localparam logic [15:0] RST_GAIN_LOWER = 16'h0800;
	localparam logic [15:0] RST_GAIN_UPPER = 16'hFFF1;
	localparam logic [15:0] RST_WINDOW_CONTROL = 16'h0000;
	localparam logic [15:0] RST_ANALOG_GAIN_CONTROL = 16'h0000;
	localparam logic [15:0] RST_WINDOW = 16'h0000;
	localparam logic [15:0] RST_EXPOSURE = 16'h0100;
	localparam logic [11:0] UNITY_DIG = 12'h080;
	localparam logic signed [12:0] LARGE_ERR = 13'sh0010;
	localparam logic signed [12:0] HYST_ERR = 13'sh0002;
	localparam logic [5:0] DIV_STEPS = 6'h20;
	localparam logic [9:0] PIX_MAX = 10'h3FF;
	typedef enum logic [2:0] {
		AEC_IDLE = 3'b001,
		AEC_DIVIDE = 3'b010,
		AEC_ADJUST = 3'b100
	} aec_state_t;
endpackage : aec_pkg

// ---- auto_exposure_controller_tb.sv ----
/*
 Testbench of the auto exposure controller: register model, pixel path and loop checks.
 Assumes aec_pkg and aec_core are compiled before it.
*/
`timescale 1ns/1ps
module auto_exposure_controller_tb
	import aec_pkg::*;
;
	localparam logic [7:0] REGS [15] = '{ADDR_EXPOSURE_CONTROL, ADDR_TARGET_INTENSITY, ADDR_RED_WEIGHT,
		ADDR_FIRST_GREEN_WEIGHT, ADDR_SECOND_GREEN_WEIGHT, ADDR_BLUE_WEIGHT, ADDR_INTEGRATION_LOWER_BOUND,
		ADDR_GAIN_LOWER_BOUNDS, ADDR_INTEGRATION_UPPER_BOUND, ADDR_GAIN_UPPER_BOUNDS, ADDR_STATISTICS_WINDOW_CONTROL,
		ADDR_ANALOG_GAIN_CONTROL, ADDR_STATISTICS_WINDOW_0, ADDR_STATISTICS_WINDOW_1, ADDR_STATISTICS_WINDOW_2};
	logic core_clk, sys_rst, reg_wr, frame_start, frame_end, pix_valid, pix_repeat, out8_mode;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, manual_exposure, exposure_out, ev, lo, hi;
	logic [9:0] pix_data, pix_out_data, sv_data;
	logic [1:0] pix_colour, manual_mux_gain, manual_afe_gain, mux_gain_out, afe_gain_out;
	logic [11:0] pix_x, pix_y, manual_dig_gain, dig_gain_out;
	logic pix_out_valid, chk_pix, sv_valid;
	logic [15:0] model [0:255];
	logic [15:0] msk [0:255];
	int err_count, compares, cyc, seed;

	aec_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_start(frame_start), .frame_end(frame_end),
		.pix_valid(pix_valid), .pix_repeat(pix_repeat), .pix_data(pix_data), .pix_colour(pix_colour),
		.pix_x(pix_x), .pix_y(pix_y), .out8_mode(out8_mode), .manual_exposure(manual_exposure),
		.manual_mux_gain(manual_mux_gain), .manual_afe_gain(manual_afe_gain), .manual_dig_gain(manual_dig_gain),
		.exposure_out(exposure_out), .mux_gain_out(mux_gain_out), .afe_gain_out(afe_gain_out),
		.dig_gain_out(dig_gain_out), .pix_out_valid(pix_out_valid), .pix_out_data(pix_out_data));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic complete_run;
		if (err_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic mp(input logic [7:0] a, input logic [15:0] r, input logic [15:0] m);
		model[a] = r;
		msk[a] = m;
	endtask : mp

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		model[a] = d & msk[a];
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		@(posedge core_clk);
		#1;
		chk("reg_rdata", model[a], reg_rdata);
	endtask : rd

	function automatic logic [15:0] dg(input logic [9:0] p, input logic [11:0] g);
		logic [21:0] m;
		m = p * g;
		m = m >> 7;
		return (m > 22'h3FF) ? 16'h03FF : 16'(m);
	endfunction : dg

	// Sampled pixels carry v, every other pixel carries its inverse
	task automatic frame(input logic [9:0] v, input logic ws);
		int n;
		logic el;
		n = 0;
		@(posedge core_clk);
		frame_start <= 1'b1;
		@(posedge core_clk);
		frame_start <= 1'b0;
		for (int y = 0; y < 8; y++) begin
			for (int x = 0; x < 8; x++) begin
				el = (x != 7) && (y != 0) && (!ws || (x >= 2 && x <= 5 && y >= 2 && y <= 5));
				@(posedge core_clk);
				pix_valid <= (x != 7);
				pix_repeat <= (y == 0);
				pix_x <= 12'(x);
				pix_y <= 12'(y);
				pix_colour <= {y[0], x[0]};
				pix_data <= (el && n % 4 == 0) ? v : ~v;
				n += int'(el);
			end
		end
		@(posedge core_clk);
		pix_valid <= 1'b0;
		frame_end <= 1'b1;
		@(posedge core_clk);
		frame_end <= 1'b0;
		repeat (40) @(posedge core_clk);
		#1;
	endtask : frame

	task automatic run(input logic [9:0] v, input logic ws, input logic [15:0] fin, input logic [1:0] mx);
		logic chg;
		chg = 1'b0;
		for (int k = 0; k < 32; k++) begin
			ev = exposure_out;
			@(posedge core_clk);
			manual_exposure <= 16'($random(seed));
			frame(v, ws);
			if (chg) chk("exposure_every_other", ev, exposure_out);
			chg = !chg && (exposure_out !== ev);
			chk("exposure_in_bounds", 16'h0001, 16'(exposure_out >= lo && exposure_out <= hi));
			chk("mux_in_bounds", 16'h0001, 16'(mux_gain_out <= 2'h1));
			chk("afe_gain_out", 16'h0000, 16'(afe_gain_out));
			chk("dig_in_bounds", 16'h0001, 16'(dig_gain_out >= 12'h080));
		end
		chk("exposure_final", fin, exposure_out);
		chk("mux_final", 16'(mx), 16'(mux_gain_out));
	endtask : run

	// Pixel path: one cycle later, scaled by digital gain only
	always @(posedge core_clk) begin
		#1;
		if (chk_pix) begin
			chk("pix_out_valid", 16'(sv_valid), 16'(pix_out_valid));
			if (sv_valid) chk("pix_out_data", dg(sv_data, manual_dig_gain), 16'(pix_out_data));
		end
		sv_valid = pix_valid;
		sv_data = pix_data;
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			complete_run();
		end
	end

	initial begin
		seed = 32'he5eaa1cf;
		{sys_rst, reg_wr, frame_start, frame_end, pix_valid, pix_repeat, out8_mode, chk_pix} = 8'h80;
		{reg_addr, reg_wdata, pix_data, pix_colour, pix_x, pix_y} = '0;
		{manual_exposure, manual_mux_gain, manual_afe_gain} = {RST_EXPOSURE, 4'h0};
		manual_dig_gain = UNITY_DIG;
		for (int k = 0; k < 256; k++) begin
			mp(8'(k), 16'h0000, 16'h0000);
		end
		mp(ADDR_EXPOSURE_CONTROL, RST_EXPOSURE_CONTROL, 16'hFFFD);
		for (int k = 1; k < 6; k++) mp(REGS[k], (k == 1) ? RST_TARGET : RST_WEIGHT, 16'h03FF);
		mp(ADDR_INTEGRATION_LOWER_BOUND, RST_INT_LOWER, 16'hFFFF);
		mp(ADDR_GAIN_LOWER_BOUNDS, RST_GAIN_LOWER, 16'hFFFF);
		mp(ADDR_INTEGRATION_UPPER_BOUND, RST_INT_UPPER, 16'hFFFF);
		mp(ADDR_GAIN_UPPER_BOUNDS, RST_GAIN_UPPER, 16'hFFFF);
		mp(ADDR_STATISTICS_WINDOW_CONTROL, RST_WINDOW_CONTROL, 16'hFFFF);
		mp(ADDR_ANALOG_GAIN_CONTROL, RST_ANALOG_GAIN_CONTROL, 16'hFFFF);
		mp(ADDR_STATISTICS_WINDOW_0, RST_WINDOW, 16'hFFFF);
		mp(ADDR_STATISTICS_WINDOW_1, RST_WINDOW, 16'h0FFF);
		mp(ADDR_STATISTICS_WINDOW_2, RST_WINDOW, 16'h0FFF);
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int k = 0; k < 15; k++) rd(REGS[k]);
		rd(8'hA6);
		for (int k = 1; k < 15; k++) wr(REGS[k], 16'($random(seed)));
		for (int k = 1; k < 15; k++) rd(REGS[k]);
		wr(8'hA7, 16'($random(seed)));
		rd(8'hA7);
		wr(ADDR_EXPOSURE_CONTROL, 16'h0002);
		rd(ADDR_EXPOSURE_CONTROL);
		wr(ADDR_INTEGRATION_LOWER_BOUND, RST_INT_LOWER);
		wr(ADDR_GAIN_LOWER_BOUNDS, RST_GAIN_LOWER);
		wr(ADDR_INTEGRATION_UPPER_BOUND, RST_INT_UPPER);
		wr(ADDR_GAIN_UPPER_BOUNDS, RST_GAIN_UPPER);
		wr(ADDR_ANALOG_GAIN_CONTROL, 16'h0000);
		manual_exposure <= 16'($random(seed)) | 16'h0001;
		manual_dig_gain <= 12'($random(seed)) | UNITY_DIG;
		manual_mux_gain <= 2'($random(seed)) & 2'h1;
		frame(10'($random(seed)), 1'b0);
		chk_pix = 1'b1;
		frame(10'($random(seed)), 1'b0);
		chk_pix = 1'b0;
		chk("exposure_manual", manual_exposure, exposure_out);
		chk("dig_manual", 16'(manual_dig_gain), 16'(dig_gain_out));
		chk("mux_manual", 16'(manual_mux_gain), 16'(mux_gain_out));
		lo = 16'h00C0;
		hi = 16'h0140;
		wr(ADDR_TARGET_INTENSITY, 16'h0200);
		for (int k = 2; k < 6; k++) wr(REGS[k], RST_WEIGHT);
		wr(ADDR_INTEGRATION_LOWER_BOUND, lo);
		wr(ADDR_INTEGRATION_UPPER_BOUND, hi);
		wr(ADDR_STATISTICS_WINDOW_0, 16'h0502);
		wr(ADDR_STATISTICS_WINDOW_1, 16'h0002);
		wr(ADDR_STATISTICS_WINDOW_2, 16'h0005);
		wr(ADDR_STATISTICS_WINDOW_CONTROL, 16'h0000);
		wr(ADDR_ANALOG_GAIN_CONTROL, 16'h2000);
		wr(ADDR_EXPOSURE_CONTROL, 16'h0001);
		run(10'h000, 1'b0, hi, 2'h1);
		wr(ADDR_STATISTICS_WINDOW_CONTROL, 16'h0400);
		out8_mode <= 1'b1;
		wr(ADDR_EXPOSURE_CONTROL, 16'h0003);
		rd(ADDR_EXPOSURE_CONTROL);
		run(10'h3FF, 1'b1, lo, 2'h0);
		wr(ADDR_TARGET_INTENSITY, 16'h0203);
		wr(ADDR_EXPOSURE_CONTROL, 16'h0003);
		run(10'h200, 1'b1, lo, 2'h0);
		chk("dig_8bit_target", 16'(UNITY_DIG), 16'(dig_gain_out));
		complete_run();
	end
endmodule : auto_exposure_controller_tb
